// >>> inc/schp_pkg.sv
// constants and types shared by the smart card coupler host port
package schp_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned SCHP_CLK_PERIOD_NS   = 10;      // mclk at 100 MHz
    localparam int unsigned SCHP_FILTER_TIME_NS  = 50_000;  // card detect filter, 50 us
    // least time, so round up to whole cycles
    localparam int unsigned SCHP_FILTER_CYCLES   =
        (SCHP_FILTER_TIME_NS + SCHP_CLK_PERIOD_NS - 1) / SCHP_CLK_PERIOD_NS;
    localparam int unsigned SCHP_FILTER_CNT_W    = 16;      // wide enough for the filter count

    // ----------------------------------------------------------------
    // programming command groups, picked by the two select lines
    // ----------------------------------------------------------------
    localparam logic [1:0] SCHP_CMD_CLK_RATIO  = 2'h0;     // reset/io = ratio code
    localparam logic [1:0] SCHP_CMD_CLK_STOP   = 2'h1;     // io = stop on, reset = stop level
    localparam logic [1:0] SCHP_CMD_DET_POL    = 2'h2;     // io = normally closed switch
    localparam logic [1:0] SCHP_CMD_NONE       = 2'h3;     // spare, ignored

    // ----------------------------------------------------------------
    // clock ratio codes
    // ----------------------------------------------------------------
    localparam logic [1:0] SCHP_DIV_1          = 2'h0;
    localparam logic [1:0] SCHP_DIV_2          = 2'h1;
    localparam logic [1:0] SCHP_DIV_4          = 2'h2;
    localparam logic [1:0] SCHP_DIV_8          = 2'h3;

    // ----------------------------------------------------------------
    // status sources, picked by the two select lines
    // ----------------------------------------------------------------
    localparam logic [1:0] SCHP_STS_CARD       = 2'h0;     // card present
    localparam logic [1:0] SCHP_STS_BATTERY    = 2'h1;     // battery good
    localparam logic [1:0] SCHP_STS_CONVERTER  = 2'h2;     // converter running and in range
    localparam logic [1:0] SCHP_STS_CARD_ALT   = 2'h3;     // card present again

    // ----------------------------------------------------------------
    // values after battery start-up
    // ----------------------------------------------------------------
    localparam logic [1:0] SCHP_RST_RATIO      = SCHP_DIV_1;
    localparam logic       SCHP_RST_STOP_EN    = 1'b0;
    localparam logic       SCHP_RST_STOP_LVL   = 1'b0;
    localparam logic       SCHP_RST_DET_NC     = 1'b0;     // normally open switch
    localparam logic       SCHP_RST_STATUS     = 1'b0;

    // direction of the serial line repeater
    typedef enum logic [1:0] {
        SCHP_IO_IDLE,
        SCHP_IO_HOST_TO_CARD,
        SCHP_IO_CARD_TO_HOST
    } schp_io_dir_t;

endpackage

// >>> core/schp_detect_filter.sv
// debounce filter for the card detect pin
`timescale 1ns/1ps
`default_nettype none
module schp_detect_filter
    import schp_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = SCHP_FILTER_CYCLES
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic rawIn,
    output var  logic stableOut
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                         stable;  // accepted pin level
        logic [SCHP_FILTER_CNT_W-1:0] count;   // cycles the pin has differed
    } schp_filt_state_t;

    localparam logic [SCHP_FILTER_CNT_W-1:0] LAST_COUNT =
        SCHP_FILTER_CNT_W'(FILTER_CYCLES - 1);

    schp_filt_state_t st_reg;   // registered state
    schp_filt_state_t st_next;  // next state

    // ----------------------------------------------------------------
    // filter: a new level must hold the whole window before it is taken
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (rawIn == st_reg.stable) begin
            // any bounce back restarts the window
            st_next.count = '0;
        end else if (st_reg.count >= LAST_COUNT) begin
            st_next.stable = rawIn;
            st_next.count  = '0;
        end else begin
            st_next.count = st_reg.count + 1'b1;
        end
    end

    // pin idles high through its pull-up, so start from high
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '{stable: 1'b1, count: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign stableOut = st_reg.stable;

endmodule
`default_nettype wire

// >>> core/schp_host_port.sv
// host port of the smart card coupler: select, programming, status, interrupt, card clock
`timescale 1ns/1ps
`default_nettype none
module schp_host_port
    import schp_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = SCHP_FILTER_CYCLES  // shorten in simulation
) (
    input  wire logic mclk,             // system clock, 100 MHz
    input  wire logic reset_n,          // battery start-up reset
    // host side
    input  wire logic chipSelectN,      // chip select, low selects
    input  wire logic selectLineLow,    // select line, low bit
    input  wire logic selectLineHigh,   // select line, high bit
    input  wire logic programStrobeN,   // program strobe, low programs
    input  wire logic powerRequest,     // converter on/off request
    input  wire logic hostResetIn,      // host reset line
    input  wire logic hostIoIn,         // host serial line, pin level
    output var  logic hostIoOut,        // host serial line, driven level
    output var  logic hostIoOe,         // host serial line, drive enable
    output var  logic statusOut,        // status line
    output var  logic intOut,           // interrupt, driven level
    output var  logic intOe,            // interrupt, drive enable (low active pin)
    input  wire logic clockIn,          // incoming card clock source, sampled
    // card side
    input  wire logic cardPresenceIn,   // card detect switch
    input  wire logic cardSerialIn,     // card serial line, pin level
    output var  logic cardSerialOut,    // card serial line, driven level
    output var  logic cardSerialOe,     // card serial line, drive enable
    output var  logic cardResetOut,     // card reset
    output var  logic cardClockOut,     // card clock
    // supply monitor and converter
    input  wire logic batteryLow,       // battery below its limit
    input  wire logic supplyLow,        // card supply below its limit
    input  wire logic supplyOverload,   // card supply overloaded
    output var  logic converterOn       // converter enable
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic         csPrev;     // chip select, last cycle
        logic         pwrPrev;    // power request, last cycle
        logic         clkPrev;    // clock source, last cycle
        logic         presPrev;   // debounced presence, last cycle
        logic         batPrev;    // battery low, last cycle
        logic         ovlPrev;    // overload, last cycle
        logic         progMode;   // programming sequence in progress
        logic [1:0]   lastSel;    // select lines seen while selected
        logic         lastReset;  // reset line seen while selected
        logic         lastIo;     // serial line seen while selected
        logic         convOn;     // converter enable
        logic         cardRst;    // card reset level
        schp_io_dir_t ioDir;      // repeater direction
        logic         hostOe;     // drive host line low
        logic         cardOe;     // drive card line low
        logic         status;     // status line level
        logic         intPend;    // interrupt pending, pin low
        logic [1:0]   divCnt;     // source edges counted
        logic         cardClk;    // card clock level
        logic [1:0]   clkRatio;   // programmed ratio
        logic         stopEn;     // card clock stopped
        logic         stopLevel;  // level while stopped
        logic         detNc;      // normally closed switch
    } schp_state_t;

    schp_state_t st_reg;   // registered state
    schp_state_t st_next;  // next state

    logic detFiltered;     // debounced detect pin
    logic present;         // card present after polarity

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic riseOf(input logic prev, input logic cur);
        riseOf = !prev && cur;
    endfunction

    function automatic logic fallOf(input logic prev, input logic cur);
        fallOf = prev && !cur;
    endfunction

    // ----------------------------------------------------------------
    // card detect filter
    // ----------------------------------------------------------------
    schp_detect_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_filter (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .rawIn     (cardPresenceIn),
        .stableOut (detFiltered)
    );

    // open switch closes to ground on insert, closed switch opens on insert
    assign present = st_reg.detNc ? detFiltered : !detFiltered;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic selected;   // chip select low
        logic csRise;     // deselect edge
        logic csFall;     // select edge
        logic setInt;     // an interrupt event this cycle
        logic clrInt;     // an acknowledge this cycle
        logic clkRise;    // source clock rising edge
        logic ioFree;     // repeater may pick a direction
        logic [1:0] half; // source edges per card clock half period, less one

        selected = 1'b0;
        csRise   = 1'b0;
        csFall   = 1'b0;
        setInt   = 1'b0;
        clrInt   = 1'b0;
        clkRise  = 1'b0;
        ioFree   = 1'b0;
        half     = 2'h0;
        st_next  = st_reg;

        selected = !chipSelectN;
        csRise   = riseOf(st_reg.csPrev, chipSelectN);
        csFall   = fallOf(st_reg.csPrev, chipSelectN);

        st_next.csPrev   = chipSelectN;
        st_next.pwrPrev  = powerRequest;
        st_next.clkPrev  = clockIn;
        st_next.presPrev = present;
        st_next.batPrev  = batteryLow;
        st_next.ovlPrev  = supplyOverload;

        // host controls only seen while selected
        if (selected) begin
            st_next.lastSel   = {selectLineHigh, selectLineLow};
            st_next.lastReset = hostResetIn;
            st_next.lastIo    = hostIoIn;
        end

        // programming latched on any selected cycle with strobe low, select edge included; strobe may then rise
        if (csFall && !programStrobeN) begin
            st_next.progMode = 1'b1;
        end else if (selected && !programStrobeN) begin
            st_next.progMode = 1'b1;
        end

        // apply the command at the deselect edge, using the last seen data
        if (csRise && st_reg.progMode) begin
            st_next.progMode = 1'b0;
            case (st_reg.lastSel)
                SCHP_CMD_CLK_RATIO: begin
                    st_next.clkRatio = {st_reg.lastReset, st_reg.lastIo};
                end
                SCHP_CMD_CLK_STOP: begin
                    st_next.stopEn    = st_reg.lastIo;
                    st_next.stopLevel = st_reg.lastReset;
                end
                SCHP_CMD_DET_POL: begin
                    st_next.detNc = st_reg.lastIo;
                end
                default: begin
                    // spare code: settings untouched
                end
            endcase
        end

        // converter: edges only count while selected, overload wins
        if (selected && riseOf(st_reg.pwrPrev, powerRequest)) begin
            st_next.convOn = 1'b1;
        end else if (selected && fallOf(st_reg.pwrPrev, powerRequest)) begin
            st_next.convOn = 1'b0;
        end
        if (riseOf(st_reg.ovlPrev, supplyOverload)) begin
            st_next.convOn = 1'b0;
        end

        // card reset: follows host only in normal mode, held when deselected
        if (!st_reg.convOn) begin
            st_next.cardRst = 1'b0;                        // card deactivated
        end else if (selected && programStrobeN && !st_reg.progMode && powerRequest) begin
            st_next.cardRst = hostResetIn;
        end                                                // else held

        // serial repeater: whichever side pulls low first owns the line
        // a low that we drive ourselves must not look like the far side
        ioFree = selected && programStrobeN && !st_reg.progMode;
        case (st_reg.ioDir)
            SCHP_IO_IDLE: begin
                if (ioFree && !hostIoIn && !st_reg.hostOe) begin
                    st_next.ioDir = SCHP_IO_HOST_TO_CARD;
                end else if (ioFree && !cardSerialIn && !st_reg.cardOe) begin
                    st_next.ioDir = SCHP_IO_CARD_TO_HOST;
                end
            end
            SCHP_IO_HOST_TO_CARD: begin
                if (!selected || hostIoIn) begin
                    st_next.ioDir = SCHP_IO_IDLE;
                end
            end
            SCHP_IO_CARD_TO_HOST: begin
                if (!selected || cardSerialIn) begin
                    st_next.ioDir = SCHP_IO_IDLE;
                end
            end
            default: begin
                st_next.ioDir = SCHP_IO_IDLE;
            end
        endcase
        st_next.hostOe = (st_next.ioDir == SCHP_IO_CARD_TO_HOST);
        // deselected: card sees the held host level, not the live pin
        if (!selected) begin
            st_next.cardOe = st_reg.convOn && !st_next.lastIo;
        end else begin
            st_next.cardOe = (st_next.ioDir == SCHP_IO_HOST_TO_CARD);
        end

        // status mux only in normal mode while selected
        if (selected && programStrobeN && !st_reg.progMode) begin
            case ({selectLineHigh, selectLineLow})
                SCHP_STS_CARD:      st_next.status = present;
                SCHP_STS_BATTERY:   st_next.status = !batteryLow;
                SCHP_STS_CONVERTER: st_next.status = st_reg.convOn && !supplyLow;
                SCHP_STS_CARD_ALT:  st_next.status = present;
                default:            st_next.status = st_reg.status;
            endcase
        end

        // interrupt: card change, battery fall, overload; set beats clear
        setInt = (present != st_reg.presPrev)
              || riseOf(st_reg.batPrev, batteryLow)
              || riseOf(st_reg.ovlPrev, supplyOverload);
        clrInt = csRise || riseOf(st_reg.pwrPrev, powerRequest);
        if (setInt) begin
            st_next.intPend = 1'b1;
        end else if (clrInt) begin
            st_next.intPend = 1'b0;
        end

        // card clock: count source rising edges, toggle every half period
        clkRise = riseOf(st_reg.clkPrev, clockIn);
        case (st_reg.clkRatio)
            SCHP_DIV_2: half = 2'h0;
            SCHP_DIV_4: half = 2'h1;
            SCHP_DIV_8: half = 2'h3;
            default:    half = 2'h0;
        endcase
        if (st_reg.stopEn) begin
            st_next.cardClk = st_reg.stopLevel;            // parked at stop level
            st_next.divCnt  = 2'h0;
        end else if (st_reg.clkRatio == SCHP_DIV_1) begin
            st_next.cardClk = clockIn;                     // one cycle late copy
            st_next.divCnt  = 2'h0;
        end else if (clkRise) begin
            if (st_reg.divCnt >= half) begin
                st_next.cardClk = !st_reg.cardClk;
                st_next.divCnt  = 2'h0;
            end else begin
                st_next.divCnt = st_reg.divCnt + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register, settings back to defaults at battery start-up
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '{
                csPrev:    1'b1,
                pwrPrev:   1'b0,
                clkPrev:   1'b0,
                presPrev:  1'b0,
                batPrev:   1'b0,
                ovlPrev:   1'b0,
                progMode:  1'b0,
                lastSel:   2'h0,
                lastReset: 1'b0,
                lastIo:    1'b1,
                convOn:    1'b0,
                cardRst:   1'b0,
                ioDir:     SCHP_IO_IDLE,
                hostOe:    1'b0,
                cardOe:    1'b0,
                status:    SCHP_RST_STATUS,
                intPend:   1'b0,
                divCnt:    2'h0,
                cardClk:   1'b0,
                clkRatio:  SCHP_RST_RATIO,
                stopEn:    SCHP_RST_STOP_EN,
                stopLevel: SCHP_RST_STOP_LVL,
                detNc:     SCHP_RST_DET_NC
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all from the state register or tied low
    // ----------------------------------------------------------------
    // open-drain lines only ever drive low; the wire pulls them high
    assign hostIoOut     = 1'b0;
    assign hostIoOe      = st_reg.hostOe;
    assign cardSerialOut = 1'b0;
    assign cardSerialOe  = st_reg.cardOe;
    assign intOut        = 1'b0;
    assign intOe         = st_reg.intPend;   // wired with other couplers
    assign statusOut     = st_reg.status;
    assign cardResetOut  = st_reg.cardRst;
    assign cardClockOut  = st_reg.cardClk;
    assign converterOn   = st_reg.convOn;

endmodule
`default_nettype wire

// >>> tb/schp_host_port_chk.sv
// pin-level assertions for the coupler host port
`timescale 1ns/1ps
`default_nettype none
module schp_host_port_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic chipSelectN,
    input wire logic programStrobeN,
    input wire logic powerRequest,
    input wire logic supplyOverload,
    input wire logic batteryLow,
    input wire logic statusOut,
    input wire logic intOut,
    input wire logic intOe,
    input wire logic hostIoOut,
    input wire logic cardSerialOut,
    input wire logic cardResetOut,
    input wire logic converterOn
);
    // ----
    // converter requests, only seen while selected
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence pwrRise;
        !chipSelectN && !powerRequest ##1 !chipSelectN && powerRequest;
    endsequence
    sequence pwrFall;
        !chipSelectN && powerRequest ##1 !chipSelectN && !powerRequest;
    endsequence
    a_conv_on_rise: assert property (pwrRise ##0 !supplyOverload |-> ##[1:3] converterOn)
        else $error("converter did not start");
    a_conv_off_fall: assert property (pwrFall |-> ##[1:3] !converterOn)
        else $error("converter did not stop");
    a_conv_needs_cs: assert property ($rose(converterOn) |->
        !$past(chipSelectN) || !$past(chipSelectN, 2))
        else $error("converter started while deselected");
    a_overload_stop: assert property ($rose(supplyOverload) |-> ##[1:3] !converterOn)
        else $error("overload left converter on");
    a_status_frozen: assert property (!$past(programStrobeN) |-> $stable(statusOut))
        else $error("status moved while strobe low");
    a_status_unsel: assert property ($past(chipSelectN) |-> $stable(statusOut))
        else $error("status moved while deselected");
    a_rst_held: assert property ($past(chipSelectN) && $past(converterOn) && converterOn
        |-> $stable(cardResetOut))
        else $error("card reset moved while deselected");
    a_rst_unpowered: assert property (!converterOn [*2] |-> !cardResetOut)
        else $error("card reset high with converter off");
    a_int_clear: assert property ($rose(chipSelectN) && !batteryLow && !supplyOverload
        |-> ##[1:2] !intOe)
        else $error("interrupt not released");
    a_int_raise: assert property ($rose(batteryLow) || $rose(supplyOverload)
        |-> ##[1:3] intOe)
        else $error("interrupt not raised");
    a_pins_open: assert property (!intOut && !hostIoOut && !cardSerialOut)
        else $error("open drain pin driven high");
endmodule
bind schp_host_port schp_host_port_chk chk_u (.mclk, .reset_n, .chipSelectN, .programStrobeN,
    .powerRequest, .supplyOverload, .batteryLow, .statusOut, .intOut, .intOe, .hostIoOut,
    .cardSerialOut, .cardResetOut, .converterOn);
`default_nettype wire

// >>> tb/schp_line_model.sv
// pulled-up open drain wires and the card and host line drivers
`timescale 1ns/1ps
`default_nettype none
module schp_line_model (
    input  wire logic hostIoOe,
    input  wire logic cardSerialOe,
    input  wire logic intOe,
    input  wire logic hostPullLow,
    input  wire logic cardPullLow,
    output var  logic hostIoPin,
    output var  logic cardSerialPin,
    output var  logic intPin
);
    // pull-ups win unless some party pulls low
    assign hostIoPin = !(hostIoOe || hostPullLow);
    assign cardSerialPin = !(cardSerialOe || cardPullLow);
    assign intPin = !intOe; // wired interrupt
endmodule
`default_nettype wire

// >>> tb/schp_host_port_bench.sv
// self-checking bench for the coupler host port
`timescale 1ns/1ps
`default_nettype none
module schp_host_port_bench;
    import schp_pkg::*;
    localparam int FILT = 8; // short filter keeps the run brief
    logic mclk = 0, reset_n = 0, csN = 1, sl = 0, sh = 0, pgmN = 1, pwr = 0, rin = 0;
    logic hpl = 0, cpl = 0, cin = 0, det = 1, bat = 0, sup = 0, ovl = 0, pc;
    wire logic hPin, cPin, iPin, hOe, cOe, iOe, sts, cRst, cClk, conv;
    int failCount = 0, checked = 0, n, seed;
    schp_host_port #(.FILTER_CYCLES(FILT)) dut_u (.mclk, .reset_n, .chipSelectN(csN),
        .selectLineLow(sl), .selectLineHigh(sh), .programStrobeN(pgmN), .powerRequest(pwr),
        .hostResetIn(rin), .hostIoIn(hPin), .hostIoOut(), .hostIoOe(hOe), .statusOut(sts),
        .intOut(), .intOe(iOe), .clockIn(cin), .cardPresenceIn(det), .cardSerialIn(cPin),
        .cardSerialOut(), .cardSerialOe(cOe), .cardResetOut(cRst), .cardClockOut(cClk),
        .batteryLow(bat), .supplyLow(sup), .supplyOverload(ovl), .converterOn(conv));
    schp_line_model line_u (.hostIoOe(hOe), .cardSerialOe(cOe), .intOe(iOe),
        .hostPullLow(hpl), .cardPullLow(cpl), .hostIoPin(hPin), .cardSerialPin(cPin),
        .intPin(iPin));
    // ----
    // helpers
    // ----
    initial forever #5 mclk = ~mclk;
    task automatic step(int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // card clock rises over 64 source periods at ratio code k
    function automatic int ratioRises(int k);
        return 64 >> k;
    endfunction
    task automatic conclude();
        if (failCount == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one programming access; strobe returns high before the select rise
    task automatic prog(logic [1:0] cmd, logic r, logic io);
        csN = 0; pgmN = 0; {sh, sl} = cmd; rin = r; hpl = !io;
        step(1);
        pgmN = 1;
        step(1);
        csN = 1;
        step(2);
        hpl = 0;
    endtask
    // a short normal-mode access that samples the status source
    task automatic sel(logic [1:0] s);
        csN = 0; {sh, sl} = s;
        step(2);
        csN = 1;
        step(2);
    endtask
    initial begin
        #900_000 failCount++; // hang limit
        conclude();
    end
    // ----
    // main sequence
    // ----
    initial begin
        seed = 32'h781c_9553;
        step(3);
        reset_n = 1;
        check("reset pins", {hOe, cOe, iOe, conv}, 4'h0);
        check("reset card", {1'b0, sts, cRst, cClk}, 4'h0);
        for (int k = 0; k < 4; k++) begin
            prog(SCHP_CMD_CLK_RATIO, k[1], k[0]);
            n = 0; pc = cClk;
            for (int t = 0; t < 256; t++) begin
                cin = t[1]; step(1);
                n += int'(cClk && !pc); pc = cClk;
            end
            check("clock ratio", 4'(n >= ratioRises(k) - 1 && n <= ratioRises(k)), 4'h1);
        end
        prog(SCHP_CMD_CLK_STOP, 1, 1); // park the card clock high
        cin = 1; step(3); cin = 0; step(3);
        check("clock stop", {3'h0, cClk}, 4'h1);
        prog(SCHP_CMD_CLK_STOP, 0, 0);
        det = 0; step(FILT - 3); det = 1; step(FILT + 4); // too short to count
        check("glitch", {3'h0, iOe}, 4'h0);
        det = 0; step(FILT + 4);
        check("insert int", {3'h0, iPin}, 4'h0);
        sel(SCHP_STS_CARD);
        check("present", {iOe, sts}, 4'h1);
        prog(SCHP_CMD_DET_POL, 0, 1); // early polarity set
        step(FILT + 4); sel(SCHP_STS_CARD);
        check("nc absent", {3'h0, sts}, 4'h0);
        det = 1; step(FILT + 4); sel(SCHP_STS_CARD);
        check("nc present", {3'h0, sts}, 4'h1);
        csN = 0; pwr = 1; step(4);
        check("power on", {3'h0, conv}, 4'h1);
        repeat (8) begin
            rin = 1'($random(seed)); step(2);
            check("reset pass", {3'h0, cRst}, {3'h0, rin});
            csN = 1; rin = ~rin; step(2);
            check("reset latch", {3'h0, cRst}, {3'h0, ~rin});
            csN = 0; pgmN = 0; {sh, sl} = SCHP_CMD_NONE; step(2); // a follower would flip
            check("reset cfg", {3'h0, cRst}, {3'h0, ~rin});
            csN = 1; pgmN = 1; step(2);
            bat = 1'($random(seed)); sup = 1'($random(seed)); step(4);
            sel(SCHP_STS_BATTERY);
            check("battery", {3'h0, sts}, {3'h0, !bat});
            sel(SCHP_STS_CONVERTER);
            check("supply", {3'h0, sts}, {3'h0, !sup});
            csN = 0;
        end
        bat = 0; hpl = 1; step(3);
        check("host to card", {3'h0, cOe}, 4'h1);
        hpl = 0; cpl = 1; step(3);
        check("card to host", {cOe, hOe}, 4'h1);
        csN = 1; step(3);
        check("deselected", {3'h0, hOe}, 4'h0);
        cpl = 0; csN = 0; hpl = 1; step(3);
        csN = 1; hpl = 0; step(3);
        check("io held", {3'h0, cOe}, 4'h1);
        csN = 0; pwr = 0; step(4);
        check("power off", {cOe, conv}, 4'h0);
        pwr = 1; step(4); csN = 1; step(2);
        ovl = 1; step(4);
        check("overload", {2'h0, conv, iPin}, 4'h0);
        ovl = 0; pwr = 0; step(1); pwr = 1; step(3);
        check("power rise clear", {2'h0, conv, iOe}, 4'h0);
        conclude(); // one chip select per coupler here
    end
endmodule
`default_nettype wire
